// [common/ppc_pkg.sv]
package ppc_pkg;
  // register addresses on the register port
  localparam logic [15:0] ADDR_CR4 = 16'h0512;
  localparam logic [15:0] ADDR_BASIC = 16'h04E0;
  localparam logic [15:0] ADDR_ADV = 16'h04E8;

  // field positions in port_phy_control_four
  localparam int unsigned F_LED_OFF = 15;
  localparam int unsigned F_TX_DIS = 14;
  localparam int unsigned F_RESTART = 13;
  localparam int unsigned F_FEF_DIS = 12;
  localparam int unsigned F_PWR_DN = 11;
  localparam int unsigned F_MDIX_AUTO_DIS = 10;
  localparam int unsigned F_MDIX_FORCE = 9;
  localparam int unsigned F_AN_EN = 7;
  localparam int unsigned F_SPEED = 6;
  localparam int unsigned F_DUPLEX = 5;
  localparam int unsigned F_ADV_PAUSE = 4;
  localparam int unsigned F_ADV_100FD = 3;
  localparam int unsigned F_ADV_100HD = 2;
  localparam int unsigned F_ADV_10FD = 1;
  localparam int unsigned F_ADV_10HD = 0;

  // the same fields seen through phy_basic_control_alias
  localparam int unsigned B_LED_OFF = 0;
  localparam int unsigned B_TX_DIS = 1;
  localparam int unsigned B_FEF_DIS = 2;
  localparam int unsigned B_MDIX_AUTO_DIS = 3;
  localparam int unsigned B_MDIX_FORCE = 4;
  localparam int unsigned B_DUPLEX = 8;
  localparam int unsigned B_RESTART = 9;
  localparam int unsigned B_PWR_DN = 11;
  localparam int unsigned B_AN_EN = 12;
  localparam int unsigned B_SPEED = 13;

  // advertisement field, identical place in both views
  localparam int unsigned ADV_LSB = 0;
  localparam int unsigned ADV_W = 5;

  // reset value and writable bits
  localparam logic [15:0] CR4_RESET = 16'h009F;
  localparam logic [15:0] CR4_WMASK = 16'hFEFF;
  localparam logic [15:0] ADV_WMASK = 16'h001F;
  localparam int unsigned LED_COUNT = 4;
endpackage

// [common/ppc_alias_if.sv]
`timescale 1ns/1ps
`default_nettype none
// carries the field store and write data to the alias mapper and the views back
interface ppc_alias_if;
  logic [15:0] fld;
  logic [15:0] wdata;
  logic [15:0] basic_rd;
  logic [15:0] adv_rd;
  logic [15:0] basic_wr;
  logic [15:0] adv_wr;
  modport owner(
    output fld,
    output wdata,
    input basic_rd,
    input adv_rd,
    input basic_wr,
    input adv_wr
  );
  modport mapper(
    input fld,
    input wdata,
    output basic_rd,
    output adv_rd,
    output basic_wr,
    output adv_wr
  );
endinterface
`default_nettype wire

// [rtl/ppc_alias_map.sv]
`timescale 1ns/1ps
`default_nettype none
module ppc_alias_map (
  // field store and views
  ppc_alias_if.mapper m
);
  // read views of the shared store
  always_comb begin
    m.basic_rd = 16'h0000;
    m.basic_rd[ppc_pkg::B_LED_OFF] = m.fld[ppc_pkg::F_LED_OFF];
    m.basic_rd[ppc_pkg::B_TX_DIS] = m.fld[ppc_pkg::F_TX_DIS];
    m.basic_rd[ppc_pkg::B_FEF_DIS] = m.fld[ppc_pkg::F_FEF_DIS];
    m.basic_rd[ppc_pkg::B_MDIX_AUTO_DIS] = m.fld[ppc_pkg::F_MDIX_AUTO_DIS];
    m.basic_rd[ppc_pkg::B_MDIX_FORCE] = m.fld[ppc_pkg::F_MDIX_FORCE];
    m.basic_rd[ppc_pkg::B_DUPLEX] = m.fld[ppc_pkg::F_DUPLEX];
    m.basic_rd[ppc_pkg::B_RESTART] = m.fld[ppc_pkg::F_RESTART];
    m.basic_rd[ppc_pkg::B_PWR_DN] = m.fld[ppc_pkg::F_PWR_DN];
    m.basic_rd[ppc_pkg::B_AN_EN] = m.fld[ppc_pkg::F_AN_EN];
    m.basic_rd[ppc_pkg::B_SPEED] = m.fld[ppc_pkg::F_SPEED];
    m.adv_rd = m.fld & ppc_pkg::ADV_WMASK;
  end

  // merged store value for a write through either alias
  always_comb begin
    m.basic_wr = m.fld;
    m.basic_wr[ppc_pkg::F_LED_OFF] = m.wdata[ppc_pkg::B_LED_OFF];
    m.basic_wr[ppc_pkg::F_TX_DIS] = m.wdata[ppc_pkg::B_TX_DIS];
    m.basic_wr[ppc_pkg::F_FEF_DIS] = m.wdata[ppc_pkg::B_FEF_DIS];
    m.basic_wr[ppc_pkg::F_MDIX_AUTO_DIS] = m.wdata[ppc_pkg::B_MDIX_AUTO_DIS];
    m.basic_wr[ppc_pkg::F_MDIX_FORCE] = m.wdata[ppc_pkg::B_MDIX_FORCE];
    m.basic_wr[ppc_pkg::F_DUPLEX] = m.wdata[ppc_pkg::B_DUPLEX];
    m.basic_wr[ppc_pkg::F_RESTART] = m.wdata[ppc_pkg::B_RESTART];
    m.basic_wr[ppc_pkg::F_PWR_DN] = m.wdata[ppc_pkg::B_PWR_DN];
    m.basic_wr[ppc_pkg::F_AN_EN] = m.wdata[ppc_pkg::B_AN_EN];
    m.basic_wr[ppc_pkg::F_SPEED] = m.wdata[ppc_pkg::B_SPEED];
    // advertisement bits keep their value through the basic view
    m.adv_wr = (m.fld & ~ppc_pkg::ADV_WMASK) | (m.wdata & ppc_pkg::ADV_WMASK);
    // a restart bit still standing from the write before must not fire a second time
    m.adv_wr[ppc_pkg::F_RESTART] = 1'b0;
  end
endmodule
`default_nettype wire

// [rtl/ppc_top.sv]
//
// Operation
// - led blanking bit forces all four indicator pins high
// - transmitter disable bit stops the port transmitter
// - writing one to restart bit restarts auto-negotiation once
// - far-end-fault disable bit stops fault detection and pattern sending
// - bit 10 turns automatic crossover selection off
// - with auto crossover off, bit 9 forces crossed configuration
// - negotiation enable resets to one; cleared means forced speed, duplex
// - forced speed: bit 6 one gives 100 Mb/s, zero 10 Mb/s
// - duplex from bit 5 when negotiation off or failed
// - pause capability advertised while bit 4 set, reset one
// - 100 full duplex advertised while bit 3 set, reset one
// - 100 half duplex advertised while bit 2 set, reset one
// - 10 full duplex advertised while bit 1 set, reset one
// - 10 half duplex advertised while bit 0 set, reset one
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ppc_top #(
  parameter int unsigned LEDS = ppc_pkg::LED_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  // indicator requests from the port status logic, high to light
  input wire logic [LEDS-1:0] led_req,
  // results from the negotiation engine
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic an_failed,
  // indicator pins, high is dark
  output logic port_indicator_zero_n,
  output logic port_indicator_one_n,
  output logic port_indicator_two_n,
  output logic port_indicator_three_n,
  // transceiver control
  output logic tx_disable,
  output logic an_restart,
  output logic fef_enable,
  output logic power_down,
  output logic auto_mdix_en,
  output logic force_mdix,
  output logic an_enable,
  output logic speed_100,
  output logic full_duplex,
  output logic [4:0] adv_cap
);
  // address match, used for both strobes
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  logic [15:0] fld_q;
  logic [15:0] fld_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [LEDS-1:0] ind_q;
  logic [LEDS-1:0] ind_d;
  logic tx_dis_q, restart_q, fef_q, pdn_q, amdix_q, fmdix_q;
  logic an_q, spd_q, fdx_q;
  logic tx_dis_d, restart_d, fef_d, pdn_d, amdix_d, fmdix_d;
  logic an_d, spd_d, fdx_d;
  logic [4:0] adv_q;
  logic [4:0] adv_d;
  logic wr_cr4, wr_basic, wr_adv;

  ppc_alias_if alias_if ();

  assign alias_if.fld = fld_q;
  assign alias_if.wdata = reg_wdata;

  ppc_alias_map u_map (
    .m(alias_if.mapper)
  );

  assign wr_cr4 = reg_we && hit(reg_addr, ppc_pkg::ADDR_CR4);
  assign wr_basic = reg_we && hit(reg_addr, ppc_pkg::ADDR_BASIC);
  assign wr_adv = reg_we && hit(reg_addr, ppc_pkg::ADDR_ADV);

  // field store: one copy, three views; restart clears itself after one cycle
  always_comb begin
    fld_d = fld_q;
    fld_d[ppc_pkg::F_RESTART] = 1'b0;
    if (wr_cr4) begin
      fld_d = reg_wdata & ppc_pkg::CR4_WMASK;
    end else if (wr_basic) begin
      fld_d = alias_if.basic_wr & ppc_pkg::CR4_WMASK;
    end else if (wr_adv) begin
      fld_d = alias_if.adv_wr & ppc_pkg::CR4_WMASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fld_q <= ppc_pkg::CR4_RESET;
    end else begin
      fld_q <= fld_d;
    end
  end

  // read data stands only in the cycle after the read strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_re) begin
      if (hit(reg_addr, ppc_pkg::ADDR_CR4)) begin
        rdata_d = fld_q;
      end else if (hit(reg_addr, ppc_pkg::ADDR_BASIC)) begin
        rdata_d = alias_if.basic_rd;
      end else if (hit(reg_addr, ppc_pkg::ADDR_ADV)) begin
        rdata_d = alias_if.adv_rd;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // indicator pins: blanking drives every pin high regardless of request
  generate
    for (genvar i = 0; i < LEDS; i++) begin : g_ind
      always_comb begin
        ind_d[i] = fld_q[ppc_pkg::F_LED_OFF] | ~led_req[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ind_q <= {LEDS{1'b1}};
    end else begin
      ind_q <= ind_d;
    end
  end

  // transceiver controls, registered so every pin comes from a flop
  always_comb begin
    tx_dis_d = fld_q[ppc_pkg::F_TX_DIS];
    restart_d = fld_q[ppc_pkg::F_RESTART];
    fef_d = ~fld_q[ppc_pkg::F_FEF_DIS];
    pdn_d = fld_q[ppc_pkg::F_PWR_DN];
    amdix_d = ~fld_q[ppc_pkg::F_MDIX_AUTO_DIS];
    // forcing only counts while automatic selection is off
    fmdix_d = fld_q[ppc_pkg::F_MDIX_AUTO_DIS] & fld_q[ppc_pkg::F_MDIX_FORCE];
    an_d = fld_q[ppc_pkg::F_AN_EN];
    spd_d = fld_q[ppc_pkg::F_AN_EN] ? an_speed_100 : fld_q[ppc_pkg::F_SPEED];
    // a failed negotiation falls back to the forced duplex
    if (!fld_q[ppc_pkg::F_AN_EN] || an_failed) begin
      fdx_d = fld_q[ppc_pkg::F_DUPLEX];
    end else begin
      fdx_d = an_full_duplex;
    end
    adv_d = fld_q[ppc_pkg::ADV_LSB +: ppc_pkg::ADV_W];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_dis_q <= 1'b0;
      restart_q <= 1'b0;
      fef_q <= 1'b1;
      pdn_q <= 1'b0;
      amdix_q <= 1'b1;
      fmdix_q <= 1'b0;
      an_q <= 1'b1;
      spd_q <= 1'b0;
      fdx_q <= 1'b0;
      adv_q <= 5'h1F;
    end else begin
      tx_dis_q <= tx_dis_d;
      restart_q <= restart_d;
      fef_q <= fef_d;
      pdn_q <= pdn_d;
      amdix_q <= amdix_d;
      fmdix_q <= fmdix_d;
      an_q <= an_d;
      spd_q <= spd_d;
      fdx_q <= fdx_d;
      adv_q <= adv_d;
    end
  end

  // outputs
  assign reg_rdata = rdata_q;
  assign port_indicator_zero_n = ind_q[0];
  assign port_indicator_one_n = ind_q[1];
  assign port_indicator_two_n = ind_q[2];
  assign port_indicator_three_n = ind_q[3];
  assign tx_disable = tx_dis_q;
  assign an_restart = restart_q;
  assign fef_enable = fef_q;
  assign power_down = pdn_q;
  assign auto_mdix_en = amdix_q;
  assign force_mdix = fmdix_q;
  assign an_enable = an_q;
  assign speed_100 = spd_q;
  assign full_duplex = fdx_q;
  assign adv_cap = adv_q;

  // checks on the outputs against their causes
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_led_blank: assert property (
    fld_q[ppc_pkg::F_LED_OFF] |=> (ind_q == {LEDS{1'b1}}))
    else $error("indicator lit while blanking is set");

  a_tx_disable: assert property (
    wr_cr4 |-> ##2 (tx_disable == $past(reg_wdata[ppc_pkg::F_TX_DIS], 2)))
    else $error("transmitter disable does not follow write");

  a_restart_pulse: assert property (
    (wr_cr4 && reg_wdata[ppc_pkg::F_RESTART]) |-> ##2 an_restart)
    else $error("restart write gave no restart pulse");

  a_restart_cause: assert property (
    an_restart |-> $past(wr_cr4 || wr_basic, 2))
    else $error("restart pulse without a write");

  a_fef_enable: assert property (
    wr_cr4 |-> ##2 (fef_enable != $past(reg_wdata[ppc_pkg::F_FEF_DIS], 2)))
    else $error("far end fault enable wrong after write");

  a_mdix_force: assert property (
    force_mdix |-> !auto_mdix_en)
    else $error("crossover forced while automatic selection is on");

  a_forced_speed: assert property (
    !fld_q[ppc_pkg::F_AN_EN] |=> (speed_100 == $past(fld_q[ppc_pkg::F_SPEED])))
    else $error("forced speed not applied");

  a_forced_duplex: assert property (
    (!fld_q[ppc_pkg::F_AN_EN] || an_failed)
      |=> (full_duplex == $past(fld_q[ppc_pkg::F_DUPLEX])))
    else $error("forced duplex not applied");

  a_adv_write: assert property (
    wr_adv |-> ##2 (adv_cap == $past(reg_wdata[4:0], 2)))
    else $error("advertised capabilities do not follow write");

  a_power_down: assert property (
    (wr_basic && reg_wdata[ppc_pkg::B_PWR_DN]) |-> ##2 power_down)
    else $error("power down through alias not applied");

  a_alias_shared: assert property (
    wr_basic |=> (fld_q[ppc_pkg::F_LED_OFF] == $past(reg_wdata[ppc_pkg::B_LED_OFF])))
    else $error("alias write not seen in the control register");

  a_read_idle: assert property (
    !$past(reg_re) |-> (reg_rdata == 16'h0000))
    else $error("read data outside the answer cycle");

  a_an_enable: assert property (
    wr_cr4 |-> ##2 (an_enable == $past(reg_wdata[ppc_pkg::F_AN_EN], 2)))
    else $error("negotiation enable does not follow write");
endmodule
`default_nettype wire

// [test/ppc_link_partner_model.sv]
`timescale 1ns/1ps
`default_nettype none
// far-end partner and negotiation result source, prompt or slow on request
module ppc_link_partner_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // what our port offers
  input wire logic an_restart,
  input wire logic [4:0] adv_cap,
  // partner abilities and pace
  input wire logic [3:0] own_cap,
  input wire logic slow,
  // resolved link
  output logic an_speed_100,
  output logic an_full_duplex,
  output logic an_failed
);
  logic [3:0] common;
  logic [4:0] cnt_q;

  // highest common mode wins; old results stand until a new round ends
  assign common = adv_cap[3:0] & own_cap;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 5'h00;
      an_speed_100 <= 1'b0;
      an_full_duplex <= 1'b0;
      an_failed <= 1'b0;
    end else begin
      if (an_restart) begin
        cnt_q <= slow ? 5'h14 : 5'h02;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
      if (cnt_q == 5'h01) begin
        an_failed <= (common == 4'h0);
        an_speed_100 <= |common[3:2];
        an_full_duplex <= common[3] | (common[1] & ~common[2]);
      end
    end
  end
endmodule
`default_nettype wire

// [test/ppc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ppc_top_tb;
  typedef struct {logic [15:0] w; logic [16:0] o;} ppc_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [3:0] led_req = 4'h5;
  logic [3:0] own_cap = 4'hF;
  logic slow = 1'b0;
  logic [15:0] reg_rdata;
  logic an_speed_100, an_full_duplex, an_failed, an_restart;
  logic i0, i1, i2, i3, tx_disable, fef_enable, power_down;
  logic auto_mdix_en, force_mdix, an_enable, speed_100, full_duplex;
  logic [4:0] adv_cap;
  logic [16:0] obs;
  logic [15:0] rd_q;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int pulses;
  // written word, then {dark pins, tx off, fef, pd, auto, force, an, spd, dup, adv}
  ppc_row_t rows [12] = '{
    '{16'h8000, 17'h1EA00}, '{16'h4000, 17'h15A00}, '{16'h1000, 17'h14200},
    '{16'h0800, 17'h14E00}, '{16'h0600, 17'h14900}, '{16'h0200, 17'h14A00},
    '{16'h0060, 17'h14A60}, '{16'h0040, 17'h14A40}, '{16'h0020, 17'h14A20},
    '{16'h00BF, 17'h14A9F}, '{16'h0015, 17'h14A15}, '{16'h010A, 17'h14A0A}};

  always #5 clk = ~clk;
  assign obs = {i3, i2, i1, i0, tx_disable, fef_enable, power_down, auto_mdix_en,
                force_mdix, an_enable, speed_100, full_duplex, adv_cap};

  ppc_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .led_req(led_req),
    .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex), .an_failed(an_failed),
    .port_indicator_zero_n(i0), .port_indicator_one_n(i1), .port_indicator_two_n(i2),
    .port_indicator_three_n(i3), .tx_disable(tx_disable), .an_restart(an_restart),
    .fef_enable(fef_enable), .power_down(power_down), .auto_mdix_en(auto_mdix_en),
    .force_mdix(force_mdix), .an_enable(an_enable), .speed_100(speed_100),
    .full_duplex(full_duplex), .adv_cap(adv_cap));

  ppc_link_partner_model partner (.clk(clk), .arst_n(arst_n), .an_restart(an_restart),
    .adv_cap(adv_cap), .own_cap(own_cap), .slow(slow), .an_speed_100(an_speed_100),
    .an_full_duplex(an_full_duplex), .an_failed(an_failed));

  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask

  // outputs lag the register store by one more edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    chk(obs, 17'h14A9F, "reset outputs");
    rd(ppc_pkg::ADDR_CR4);
    chk({1'b0, rd_q}, 17'h0009F, "reset word");
    rd(ppc_pkg::ADDR_BASIC);
    chk({1'b0, rd_q}, 17'h01000, "reset basic view");
    rd(ppc_pkg::ADDR_ADV);
    chk({1'b0, rd_q}, 17'h0001F, "reset advert view");
    $display("reset test done");
    foreach (rows[i]) begin
      wr(ppc_pkg::ADDR_CR4, rows[i].w);
      settle();
      chk(obs, rows[i].o, "row outputs");
      rd(ppc_pkg::ADDR_CR4);
      chk({1'b0, rd_q}, {1'b0, rows[i].w & ppc_pkg::CR4_WMASK}, "row readback");
    end
    $display("row test done");
    // restart gives one pulse; prompt partner settles on 100 full
    wr(ppc_pkg::ADDR_CR4, 16'h20BF);
    pulses = 0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (an_restart === 1'b1) pulses++;
    end
    chk(17'(pulses), 17'h00001, "restart pulses");
    rd(ppc_pkg::ADDR_CR4);
    chk({1'b0, rd_q}, 17'h000BF, "restart self clear");
    chk({15'h0000, speed_100, full_duplex}, 17'h00003, "negotiated link");
    // slow partner, only 10 half offered: old result stands meanwhile
    slow <= 1'b1;
    wr(ppc_pkg::ADDR_CR4, 16'h2081);
    repeat (10) @(posedge clk);
    #1 chk({15'h0000, speed_100, full_duplex}, 17'h00003, "slow round");
    repeat (20) @(posedge clk);
    #1 chk({15'h0000, speed_100, full_duplex}, 17'h00000, "10 half link");
    // nothing in common: failed, duplex taken from the forced bit
    slow <= 1'b0;
    wr(ppc_pkg::ADDR_CR4, 16'h20B0);
    repeat (10) @(posedge clk);
    #1 chk({15'h0000, speed_100, full_duplex}, 17'h00001, "failed round");
    $display("negotiation test done");
    // alias views share the store
    wr(ppc_pkg::ADDR_ADV, 16'hFFFF);
    rd(ppc_pkg::ADDR_CR4);
    chk({1'b0, rd_q}, 17'h000BF, "advert write seen");
    wr(ppc_pkg::ADDR_CR4, 16'h4C40);
    rd(ppc_pkg::ADDR_BASIC);
    chk({1'b0, rd_q}, 17'h0280A, "basic view");
    // unmapped place is ignored and reads zero
    wr(16'h0514, 16'hFFFF);
    rd(16'h0514);
    chk({1'b0, rd_q}, 17'h00000, "unmapped read");
    rd(ppc_pkg::ADDR_CR4);
    chk({1'b0, rd_q}, 17'h04C40, "unmapped write ignored");
    led_req <= 4'hA;
    settle();
    chk({13'h0000, i3, i2, i1, i0}, 17'h00005, "lit indicators");
    wr(ppc_pkg::ADDR_BASIC, 16'h0001);
    settle();
    chk({13'h0000, i3, i2, i1, i0}, 17'h0000F, "blank via basic");
    rd(ppc_pkg::ADDR_CR4);
    chk({1'b0, rd_q}, 17'h08000, "basic write seen");
    // restart and power down given through the basic view
    wr(ppc_pkg::ADDR_BASIC, 16'h0A00);
    @(posedge clk);
    #1 chk({16'h0000, an_restart}, 17'h00001, "restart via basic");
    settle();
    chk({16'h0000, power_down}, 17'h00001, "power down via basic");
    $display("alias test done");
    // reset in mid-run brings every field back to its default
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    led_req <= 4'h5;
    settle();
    chk(obs, 17'h14A9F, "mid-run reset outputs");
    rd(ppc_pkg::ADDR_CR4);
    chk({1'b0, rd_q}, 17'h0009F, "mid-run reset word");
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
